// ---- verilog/sar_regs.vh ----
// Purpose: constants for the sar converter register control
// Assumes: byte addressed Avalon-MM, one 32-bit word per register
// Notes:   8-bit registers sit in the low lanes, upper bits read zero
`ifndef SAR_REGS_VH
`define SAR_REGS_VH

// register byte offsets
`define SAR_OFS_STATUS_CONTROL 4'h0
`define SAR_OFS_RESULT_HIGH    4'h4
`define SAR_OFS_RESULT_LOW     4'h8
`define SAR_OFS_CLOCK_CONFIG   4'hC

// status/control fields
`define SAR_SC_DONE            7
`define SAR_SC_IRQ_EN          6
`define SAR_SC_CONT            5
`define SAR_SC_CH_HI           4
`define SAR_SC_CH_LO           0

// clock config fields
`define SAR_CK_LOW_POWER       7
`define SAR_CK_DIV_HI          6
`define SAR_CK_DIV_LO          5
`define SAR_CK_INPUT_SEL       4
`define SAR_CK_MODE_HI         3
`define SAR_CK_MODE_LO         2
`define SAR_CK_LONG_SAMPLE     1
`define SAR_CK_ASYNC_EN        0

// reset values
`define SAR_RST_CHANNEL        5'h1F
`define SAR_RST_CLOCK_CONFIG   8'h00

// codes
`define SAR_CH_OFF             5'h1F
`define SAR_MODE_8BIT          2'h0
`define SAR_MODE_10BIT         2'h1
`define SAR_DIV_1              2'h0
`define SAR_DIV_2              2'h1
`define SAR_DIV_4              2'h2
`define SAR_DIV_8              2'h3

// sample phase lengths in conversion-clock cycles, half cycle rounded up
`define SAR_SAMPLE_SHORT       5'h04
`define SAR_SAMPLE_LONG        5'h18

// successive approximation
`define SAR_MSB_TRIAL          10'h200
`define SAR_MSB_INDEX          4'h9
`define SAR_ROUND_ADD          11'h002
`define SAR_MAX8               8'hFF

`endif

// ---- verilog/sar_adc_ctrl.v ----
// Purpose: register control and sequencing of a 10-bit sar converter
// Assumes: alternate and asynchronous clocks arrive as enable pulses on clk
// Notes:   analog comparator and dac are outside, reached by cmp_above and dac_code
// Operation
// - any status/control write aborts and restarts, unless channel is all ones
// - done flag sets per conversion; cleared by status write or low result read
// - interrupt enable raises irq per conversion; data read or status write clears
// - continuous bit with valid channel converts repeatedly, refreshing results
// - continuous run ends on reset, clock write, status write, stop without async
// - status write with continuous bit starts continuous; only that restarts after stop
// - continuous clear gives one conversion per status write; reset clears the bit
// - five-bit channel field selects inputs, references or unused slots
// - channel all ones powers off and isolates; no extra conversion results
// - converter powers off (converter_on low) on its own after each conversion with continuous clear
// - unused or reserved channel results are undefined
// - high result holds upper bits, refreshed per conversion, unused bits zero
// - 10-bit mode high read locks results until low read; later results lost
// - 8-bit mode has no interlock; results written through
// - low power bit selects reduced power, otherwise high speed
// - divider field divides the input clock by 1, 2, 4 or 8
// - async clear: input select one picks bus clock, zero alternate
// - mode field picks 8-bit or 10-bit right-justified rounded; reset 8-bit
// - long sample bit gives long sample phase, otherwise short
// - async enable picks async oscillator, runs it only while converting
// - stop without async aborts the conversion; results keep last value
// - done flag sets at every conversion end regardless of irq enable
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "sar_regs.vh"

module sar_adc_ctrl #(
  parameter RES_W = 10
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        alt_clk_tick,
  input  wire        async_clk_tick,
  input  wire        stop_mode,
  input  wire        cmp_above,
  output wire        irq,
  output wire [4:0]  analog_channel,
  output wire        converter_on,
  output wire        input_isolate,
  output wire        low_power_mode,
  output wire        async_osc_run,
  output wire        sample_phase,
  output wire [9:0]  dac_code
);

  localparam [1:0] ST_IDLE    = 2'h0;
  localparam [1:0] ST_SAMPLE  = 2'h1;
  localparam [1:0] ST_CONVERT = 2'h2;

  ////////////////////////////////////////////////////////////////////
  // register state

  reg              irq_en_q;
  reg              cont_sel_q;
  reg  [4:0]       channel_q;
  reg  [7:0]       clk_cfg_q;
  reg              done_q;
  reg              done_d;
  reg              irq_q;
  reg              irq_d;
  reg              lock_q;
  reg              lock_d;
  reg  [RES_W-1:0] result_q;
  reg              ack_q;

  ////////////////////////////////////////////////////////////////////
  // sequencer state

  reg  [1:0]       state_q;
  reg  [1:0]       state_d;
  reg              cont_run_q;
  reg              cont_run_d;
  reg  [4:0]       count_q;
  reg  [4:0]       count_d;
  reg  [3:0]       bit_q;
  reg  [3:0]       bit_d;
  reg  [RES_W-1:0] sar_q;
  reg  [RES_W-1:0] sar_d;
  reg  [2:0]       div_q;
  reg              stop_q;

  ////////////////////////////////////////////////////////////////////
  // bus decode

  wire             access;
  wire             take;
  wire             wr;
  wire             rd;
  wire             lane0;
  wire             sel_sc;
  wire             sel_rh;
  wire             sel_rl;
  wire             sel_ck;

  assign access = avs_read | avs_write;
  // one wait state per access, taken on the second edge
  assign avs_waitrequest = access & ~ack_q;
  assign take = access & ack_q;
  assign wr = take & avs_write;
  assign rd = take & avs_read;
  assign lane0 = avs_byteenable[0];
  assign sel_sc = (avs_address == `SAR_OFS_STATUS_CONTROL);
  assign sel_rh = (avs_address == `SAR_OFS_RESULT_HIGH);
  assign sel_rl = (avs_address == `SAR_OFS_RESULT_LOW);
  assign sel_ck = (avs_address == `SAR_OFS_CLOCK_CONFIG);

  wire             sc_write;
  wire             ck_write;
  wire             rh_read;
  wire             rl_read;
  wire [7:0]       wdata;
  wire [4:0]       wr_channel;
  wire             wr_cont;

  assign sc_write = wr & sel_sc & lane0;
  assign ck_write = wr & sel_ck & lane0;
  assign rh_read = rd & sel_rh;
  assign rl_read = rd & sel_rl;
  assign wdata = avs_writedata[7:0];
  assign wr_channel = wdata[`SAR_SC_CH_HI:`SAR_SC_CH_LO];
  assign wr_cont = wdata[`SAR_SC_CONT];

  ////////////////////////////////////////////////////////////////////
  // clock configuration fields

  wire             cfg_low_power;
  wire [1:0]       cfg_div;
  wire             cfg_bus_clk;
  wire [1:0]       cfg_mode;
  wire             cfg_long;
  wire             cfg_async;
  wire             mode10;

  assign cfg_low_power = clk_cfg_q[`SAR_CK_LOW_POWER];
  assign cfg_div = clk_cfg_q[`SAR_CK_DIV_HI:`SAR_CK_DIV_LO];
  assign cfg_bus_clk = clk_cfg_q[`SAR_CK_INPUT_SEL];
  assign cfg_mode = clk_cfg_q[`SAR_CK_MODE_HI:`SAR_CK_MODE_LO];
  assign cfg_long = clk_cfg_q[`SAR_CK_LONG_SAMPLE];
  assign cfg_async = clk_cfg_q[`SAR_CK_ASYNC_EN];
  assign mode10 = (cfg_mode == `SAR_MODE_10BIT);

  ////////////////////////////////////////////////////////////////////
  // conversion clock: source select and divider

  wire             src_tick;
  reg              conversion_clock_tick;
  wire             busy;

  assign busy = (state_q != ST_IDLE);
  // async oscillator only runs while a conversion is under way
  assign async_osc_run = cfg_async & busy;
  assign src_tick = cfg_async ? async_clk_tick :
                    (cfg_bus_clk ? 1'b1 : alt_clk_tick);

  always @* begin
    case (cfg_div)
      `SAR_DIV_1: conversion_clock_tick = src_tick;
      `SAR_DIV_2: conversion_clock_tick = src_tick & (div_q[0] == 1'b1);
      `SAR_DIV_4: conversion_clock_tick = src_tick & (div_q[1:0] == 2'h3);
      `SAR_DIV_8: conversion_clock_tick = src_tick & (div_q == 3'h7);
      default:    conversion_clock_tick = src_tick;
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= 3'h0;
    end else if (!busy) begin
      div_q <= 3'h0;
    end else if (src_tick) begin
      div_q <= div_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // stop entry and start decisions

  wire             stop_entry;
  wire             stop_block;
  wire             start_req;
  wire             conv_end;
  wire [4:0]       sample_len;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stop_q <= 1'b0;
    end else begin
      stop_q <= stop_mode;
    end
  end

  assign stop_block = stop_mode & ~cfg_async;
  assign stop_entry = stop_block & ~stop_q;
  assign start_req = sc_write & (wr_channel != `SAR_CH_OFF);
  assign conv_end = (state_q == ST_CONVERT) & conversion_clock_tick & (bit_q == 4'h0);
  assign sample_len = cfg_long ? `SAR_SAMPLE_LONG : `SAR_SAMPLE_SHORT;

  ////////////////////////////////////////////////////////////////////
  // sequencer

  always @* begin
    state_d = state_q;
    cont_run_d = cont_run_q;
    count_d = count_q;
    bit_d = bit_q;
    sar_d = sar_q;
    case (state_q)
      ST_IDLE: begin
        count_d = 5'h00;
      end
      ST_SAMPLE: begin
        if (conversion_clock_tick) begin
          count_d = count_q + 5'h01;
          if (count_d == sample_len) begin
            state_d = ST_CONVERT;
            sar_d = `SAR_MSB_TRIAL;
            bit_d = `SAR_MSB_INDEX;
          end
        end
      end
      ST_CONVERT: begin
        if (conversion_clock_tick) begin
          if (!cmp_above) begin
            sar_d[bit_q] = 1'b0;
          end
          if (bit_q != 4'h0) begin
            bit_d = bit_q - 4'h1;
            sar_d[bit_d] = 1'b1;
          end else if (cont_run_q) begin
            state_d = ST_SAMPLE;
            count_d = 5'h00;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (ck_write) begin
      cont_run_d = 1'b0;
    end
    if (sc_write) begin
      // abort and, with a live channel, begin afresh
      cont_run_d = start_req & wr_cont;
      count_d = 5'h00;
      state_d = start_req ? ST_SAMPLE : ST_IDLE;
    end
    if (stop_entry) begin
      state_d = ST_IDLE;
      cont_run_d = 1'b0;
    end else if (stop_block && state_d != ST_IDLE) begin
      state_d = ST_IDLE;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cont_run_q <= 1'b0;
      count_q <= 5'h00;
      bit_q <= 4'h0;
      sar_q <= {RES_W{1'b0}};
    end else begin
      state_q <= state_d;
      cont_run_q <= cont_run_d;
      count_q <= count_d;
      bit_q <= bit_d;
      sar_q <= sar_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // result formatting

  wire [RES_W-1:0] final10;
  wire [10:0]      rounded;
  wire [7:0]       res8;
  wire [RES_W-1:0] res_store;

  // last comparator decision folded into the stored code
  assign final10 = {sar_q[RES_W-1:1], sar_q[0] & cmp_above};
  assign rounded = {1'b0, final10} + `SAR_ROUND_ADD;
  assign res8 = (rounded[10]) ? `SAR_MAX8 : rounded[9:2];
  assign res_store = mode10 ? final10 : {2'h0, res8};

  ////////////////////////////////////////////////////////////////////
  // flags, interlock and results

  always @* begin
    done_d = done_q;
    if (sc_write || rl_read) begin
      done_d = 1'b0;
    end
    if (conv_end) begin
      done_d = 1'b1;
    end
  end

  always @* begin
    irq_d = irq_q;
    if (sc_write || rl_read || rh_read) begin
      irq_d = 1'b0;
    end
    if (conv_end && irq_en_q) begin
      irq_d = 1'b1;
    end
  end

  always @* begin
    lock_d = lock_q;
    if (rh_read && mode10) begin
      lock_d = 1'b1;
    end
    if (rl_read || !mode10) begin
      lock_d = 1'b0;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_q <= 1'b0;
      irq_q <= 1'b0;
      lock_q <= 1'b0;
      result_q <= {RES_W{1'b0}};
    end else begin
      done_q <= done_d;
      irq_q <= irq_d;
      lock_q <= lock_d;
      // locked results are dropped, not queued
      if (conv_end && !lock_q) begin
        result_q <= res_store;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // software registers

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_en_q <= 1'b0;
      cont_sel_q <= 1'b0;
      channel_q <= `SAR_RST_CHANNEL;
      clk_cfg_q <= `SAR_RST_CLOCK_CONFIG;
      ack_q <= 1'b0;
    end else begin
      ack_q <= access & ~ack_q;
      if (sc_write) begin
        irq_en_q <= wdata[`SAR_SC_IRQ_EN];
        cont_sel_q <= wr_cont;
        channel_q <= wr_channel;
      end
      if (ck_write) begin
        clk_cfg_q <= wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data

  reg  [7:0]       rdata8;

  always @* begin
    rdata8 = 8'h00;
    if (sel_sc) begin
      rdata8 = {done_q, irq_en_q, cont_sel_q, channel_q};
    end else if (sel_rh) begin
      rdata8 = {6'h00, result_q[9:8]};
    end else if (sel_rl) begin
      rdata8 = result_q[7:0];
    end else if (sel_ck) begin
      rdata8 = clk_cfg_q;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= {24'h000000, rdata8};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // converter side outputs

  assign irq = irq_q;
  assign analog_channel = channel_q;
  assign converter_on = busy;
  assign input_isolate = (channel_q == `SAR_CH_OFF);
  assign low_power_mode = cfg_low_power;
  assign sample_phase = (state_q == ST_SAMPLE);
  assign dac_code = sar_q;

endmodule

`default_nettype wire

// ---- bench/sar_adc_ctrl_checker.sv ----
// Purpose: concurrent checks on the sar converter control ports
// Assumes: one clock, async active-high reset
// Notes:   attached to every sar_adc_ctrl by the bind below
`timescale 1ns/100ps
`default_nettype none

module sar_adc_ctrl_checker (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        stop_mode,
  input wire logic        irq,
  input wire logic [4:0]  analog_channel,
  input wire logic        converter_on,
  input wire logic        input_isolate,
  input wire logic        low_power_mode,
  input wire logic        async_osc_run,
  input wire logic        sample_phase
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire logic sc_wr = wr_ok && avs_address == 4'h0;

  AST_START: assert property (sc_wr && avs_writedata[4:0] != 5'h1F && !stop_mode
    |=> sample_phase && converter_on) else $error("no sample phase after start write");
  AST_CHANNEL: assert property (sc_wr
    |=> analog_channel == $past(avs_writedata[4:0])) else $error("channel field not taken");
  AST_ISOLATE: assert property (input_isolate == (analog_channel == 5'h1F)
    && (!input_isolate || !converter_on)) else $error("isolation does not follow channel");
  AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(converter_on))
    else $error("irq without a conversion");
  AST_IRQ_CLEAR: assert property (sc_wr && !converter_on |=> !irq)
    else $error("irq kept after status write");
  AST_LOW_POWER: assert property (wr_ok && avs_address == 4'hC
    |=> low_power_mode == $past(avs_writedata[7])) else $error("low power bit not applied");
  AST_ASYNC_RUN: assert property (async_osc_run |-> converter_on)
    else $error("async oscillator runs while idle");
  AST_HIGH_ZERO: assert property (avs_read && !avs_waitrequest && avs_address == 4'h4
    |-> avs_readdata[31:2] == 30'h0) else $error("result high unused bits set");
endmodule

bind sar_adc_ctrl sar_adc_ctrl_checker u_chk (
  .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .stop_mode(stop_mode),
  .irq(irq), .analog_channel(analog_channel), .converter_on(converter_on),
  .input_isolate(input_isolate), .low_power_mode(low_power_mode),
  .async_osc_run(async_osc_run), .sample_phase(sample_phase));
`default_nettype wire

// ---- bench/sar_analog_model.sv ----
// Purpose: comparator and input levels seen by the converter
// Assumes: ideal comparator, one fixed level per channel
// Notes:   idle or undefined channels give a changing answer
`timescale 1ns/100ps
`default_nettype none

module sar_analog_model #(
  parameter logic [59:0] LEVELS  = 60'h0,
  parameter logic [9:0]  BANDGAP = 10'h123
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [4:0] analog_channel,
  input  wire logic       converter_on,
  input  wire logic [9:0] dac_code,
  output logic            cmp_above
);
  logic       wiggle_q;
  logic       known;
  logic [9:0] level;
  always_comb begin
    known = 1'b1;
    case (analog_channel)
      5'h1A:   level = BANDGAP;
      5'h1D:   level = 10'h3FF;
      5'h1E:   level = 10'h000;
      default: begin
        known = analog_channel < 5'h06;
        level = known ? LEVELS[analog_channel*10 +: 10] : 10'h000;
      end
    endcase
    cmp_above = (converter_on && known) ? level >= dac_code : wiggle_q;
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) wiggle_q <= 1'b0;
    else wiggle_q <= ~wiggle_q;
  end
endmodule
`default_nettype wire

// ---- bench/sar_adc_ctrl_tb.sv ----
// Purpose: register level tests of the sar converter control
// Assumes: bus clock 100 MHz, alternate tick every 3, async tick every 4 cycles
// Notes:   results compared against fixed channel levels
`timescale 1ns/100ps
`default_nettype none

module sar_adc_ctrl_tb;
  localparam logic [59:0] LEVELS = {10'h201, 10'h3FE, 10'h2AB, 10'h155, 10'h000, 10'h3FF};
  localparam logic [9:0]  BANDGAP = 10'h123;
  localparam int          LIMIT = 20000;
  logic        clk, sys_rst, avs_read, avs_write, stop_mode, alt_clk_tick, async_clk_tick;
  logic        cmp_above, irq, converter_on, input_isolate, low_power_mode, async_osc_run;
  logic        avs_waitrequest, sample_phase;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic [4:0]  analog_channel;
  logic [9:0]  dac_code;
  logic [1:0]  alt_cnt = 2'h0, asy_cnt = 2'h0;
  logic [7:0]  q;
  int          fails = 0, n_compared = 0, cycles = 0, n;
  logic [4:0]  chs [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1A, 5'h1D, 5'h1E};
  logic [7:0]  cfgs [5] = '{8'h16, 8'h34, 8'h54, 8'h74, 8'h04};
  int          los [5] = '{34, 26, 52, 104, 39};
  int          his [5] = '{34, 30, 60, 120, 45};

  sar_adc_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .alt_clk_tick(alt_clk_tick),
    .async_clk_tick(async_clk_tick), .stop_mode(stop_mode), .cmp_above(cmp_above),
    .irq(irq), .analog_channel(analog_channel), .converter_on(converter_on),
    .input_isolate(input_isolate), .low_power_mode(low_power_mode),
    .async_osc_run(async_osc_run), .sample_phase(sample_phase), .dac_code(dac_code));
  sar_analog_model #(.LEVELS(LEVELS), .BANDGAP(BANDGAP)) u_model (.clk(clk),
    .sys_rst(sys_rst), .analog_channel(analog_channel), .converter_on(converter_on),
    .dac_code(dac_code), .cmp_above(cmp_above));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    alt_cnt <= (alt_cnt == 2'h2) ? 2'h0 : alt_cnt + 2'h1;
    asy_cnt <= asy_cnt + 2'h1;
    alt_clk_tick <= alt_cnt == 2'h0;
    async_clk_tick <= asy_cnt == 2'h0;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [9:0] level(input logic [4:0] ch);
    case (ch)
      5'h1A:   return BANDGAP;
      5'h1D:   return 10'h3FF;
      5'h1E:   return 10'h000;
      default: return LEVELS[ch*10 +: 10];
    endcase
  endfunction
  function automatic logic [7:0] round8(input logic [9:0] v);
    logic [10:0] r;
    r = ({1'b0, v} + 11'h002) >> 2;
    return (r > 11'h0FF) ? 8'hFF : r[7:0];
  endfunction
  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [7:0] rq);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    // waitrequest and read data as they stand at the rising edge
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rq = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] rq;
    bus(1'b1, a, d, 4'hF, rq);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string name);
    logic [7:0] rq;
    bus(1'b0, a, 8'h00, 4'hF, rq);
    check(name, {24'h0, e}, {24'h0, rq});
  endtask
  task automatic idle(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wait_irq(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
      @(negedge clk);
    end while (irq !== 1'b1 && c < 1000);
  endtask
  task automatic convert(input logic [4:0] ch, input logic ten);
    int         c;
    logic [9:0] v;
    v = level(ch);
    wr(4'h0, {3'b010, ch});
    wait_irq(c);
    check("latency", 14, c);
    check("dac_final", {22'h0, v}, {22'h0, dac_code});
    rd(4'h0, {3'b110, ch}, "done_set");
    rd(4'h4, ten ? {6'h0, v[9:8]} : 8'h00, "result_high");
    rd(4'h8, ten ? v[7:0] : round8(v), "result_low");
    idle(1);
    check("irq_clear", 0, irq);
    check("auto_idle", 0, converter_on);
    rd(4'h0, {3'b010, ch}, "done_clear");
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {avs_read, avs_write, stop_mode} = 3'h0;
    avs_address = 4'h0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0;
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(4'h0, 8'h1F, "sc_reset");
    rd(4'hC, 8'h00, "clk_reset");
    rd(4'h2, 8'h00, "unmapped");
    check("isolate_reset", 1, input_isolate);
    bus(1'b1, 4'hC, 8'hFF, 4'h0, q);
    rd(4'hC, 8'h00, "be_ignored");
    wr(4'hC, 8'h94);
    idle(1);
    check("low_power_on", 1, low_power_mode);
    wr(4'hC, 8'h14);
    idle(1);
    check("low_power_off", 0, low_power_mode);
    foreach (chs[i]) convert(chs[i], 1'b1);
    wr(4'hC, 8'h10);
    convert(5'h04, 1'b0);
    rd(4'h4, 8'h00, "high_8bit");
    wr(4'h0, 8'h42);
    wait_irq(n);
    rd(4'h8, 8'h55, "no_lock_8bit");
    wr(4'h0, 8'h05);
    idle(20);
    check("no_irq_disabled", 0, irq);
    rd(4'h0, 8'h85, "done_no_irq");
    wr(4'hC, 8'h14);
    convert(5'h02, 1'b1);
    rd(4'h4, 8'h01, "lock_high");
    wr(4'h0, 8'h43);
    wait_irq(n);
    rd(4'h8, 8'h55, "locked_low");
    convert(5'h03, 1'b1);
    for (int i = 0; i < 5; i++) begin
      wr(4'hC, cfgs[i]);
      wr(4'h0, 8'h40);
      wait_irq(n);
      check("clock_timing", 1, n >= los[i] && n <= his[i]);
      rd(4'h8, 8'hFF, "timed_result");
    end
    wr(4'hC, 8'h14);
    wr(4'h0, 8'h62);
    wait_irq(n);
    rd(4'h8, 8'h55, "cont_first");
    wait_irq(n);
    check("cont_repeat", 1, n <= 16);
    wr(4'hC, 8'h14);
    idle(30);
    check("cont_stop_clk", 0, converter_on);
    wr(4'h0, 8'h62);
    wr(4'h0, 8'h1F);
    idle(30);
    check("off_no_extra", 0, irq | converter_on);
    wr(4'h0, 8'h63);
    idle(5);
    @(posedge clk);
    stop_mode <= 1'b1;
    idle(3);
    check("stop_abort", 0, converter_on);
    @(posedge clk);
    stop_mode <= 1'b0;
    idle(30);
    check("stop_no_resume", 0, irq | converter_on);
    rd(4'h8, 8'h55, "stop_keeps");
    wr(4'hC, 8'h15);
    @(posedge clk);
    stop_mode <= 1'b1;
    wr(4'h0, 8'h40);
    idle(8);
    check("async_run", 1, async_osc_run);
    wait_irq(n);
    idle(1);
    check("async_stopped", 0, async_osc_run);
    rd(4'h8, 8'hFF, "async_result");
    @(posedge clk);
    stop_mode <= 1'b0;
    complete_run();
  end
endmodule
`default_nettype wire
